// [fh_frame_pkg.sv]
// shared constants, carrier structs and state types for the frame builder/parser
// assumes a single 250 MHz clock; every cycle count is derived from CLK_MHZ
`default_nettype none
package fh_frame_pkg;
  localparam int CLK_MHZ = 250; // device clock rate in MHz
  localparam int BASE_RATE_MBPS = 1; // header and preamble rate
  localparam int BASE_BIT_CYCLES = CLK_MHZ / BASE_RATE_MBPS; // 1 us per bit
  localparam int US_CYCLES = CLK_MHZ; // cycles per microsecond of local time
  localparam logic [6:0] SYNC_BITS = 7'h50; // 80 alternating bits
  localparam logic [6:0] SFD_BITS = 7'h10; // delimiter length
  localparam logic [15:0] SFD_PATTERN = 16'h0CBD; // 0000 1100 1011 1101, sent left first
  localparam logic [6:0] HDR_FIELD_BITS = 7'h10; // length word plus signalling field
  localparam logic [6:0] HEC_BITS = 7'h10; // header check width
  localparam logic [6:0] FCS_BITS = 7'h20; // trailing check width
  localparam logic [15:0] HEC_POLY = 16'h1021; // x16+x12+x5+1
  localparam logic [31:0] FCS_POLY = 32'h04C11DB7; // 32-bit frame check polynomial
  localparam logic [3:0] MAX_RATE_CODE = 4'h7; // 1.0 .. 4.5 Mbit/s in 0.5 steps
  localparam logic [11:0] FCS_BYTES = 12'h004; // trailing check counted in length
  localparam logic [1:0] VERSION_ZERO = 2'h0; // only supported protocol version
  localparam logic [7:0] BEACON_FC = 8'h80; // first frame-control byte of a beacon
  localparam logic [11:0] TS_FIRST_BYTE = 12'h018; // timestamp byte offset in MAC data
  localparam logic [11:0] TS_BYTES = 12'h008; // timestamp length in bytes
  localparam logic [63:0] PREAMBLE_US = 64'h60; // sync+delimiter time at base rate

  typedef struct packed {
    logic beacon; // insert on-air timestamp
    logic [2:0] rate; // payload rate code
    logic [11:0] len; // MAC bytes, trailing check excluded
  } tx_req_t;

  typedef struct packed {
    logic ok; // frame good
    logic hdr_err; // header check or field failed, frame dropped
    logic fcs_err; // trailing check mismatch
    logic ver_err; // unsupported protocol version
  } rx_status_t;

  typedef enum logic [2:0] {TX_IDLE, TX_SYNC, TX_SFD, TX_HDR, TX_DATA, TX_FCS} tx_state_t;
  typedef enum logic [1:0] {RX_HUNT, RX_HDR, RX_DATA, RX_FCS} rx_state_t;

  // cycles per bit for a rate code: CLK_MHZ / (1 + 0.5 * code), rounded down
  function automatic logic [8:0] bit_cycles(input logic [2:0] code);
    bit_cycles = 9'((2 * CLK_MHZ) / (2 + int'(code)));
  endfunction : bit_cycles
endpackage : fh_frame_pkg
`default_nettype wire

// [fh_crc_serial.sv]
// bit-serial crc register, msb-first galois form, preset to all ones
// assumes the caller holds shift_en for exactly one cycle per bit
`timescale 1ns/1ns
`default_nettype none
module fh_crc_serial #(
  parameter int W = 16,
  parameter logic [W-1:0] POLY = '1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clear,
  input wire logic shift_en,
  input wire logic din,
  output logic [W-1:0] crc
);
  logic fb; // feedback bit
  assign fb = din ^ crc[W-1];

  // clear has priority so a new frame never inherits a stale remainder
  always_ff @(posedge mclk) begin
    if (rst || clear) begin
      crc <= '1;
    end else if (shift_en) begin
      crc <= {crc[W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
  end
endmodule : fh_crc_serial
`default_nettype wire

// [fh_phy_frame_framer.sv]
// builds transmit frames bit by bit and parses received ones
// assumes the modem recovers rx bit timing and strobes rx_bit_valid once per bit
`timescale 1ns/1ns
`default_nettype none
// How it works
// - preamble, header, MAC data, check, in order
// - transmit 80 alternating sync bits first
// - 16-bit delimiter sent; receiver times from it
// - header always sent at 1 Mbit/s
// - length word; receiver counts bytes to end
// - rate code 1-4.5 Mbit/s; payload switches rate
// - 16-bit header check generated and verified
// - version sent as 0; nonzero flagged unsupported
// - beacon timestamp sampled when going on air
// - beacon arrival corrects local clock
// - 32-bit trailing check generated and verified
module fh_phy_frame_framer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tx_start,
  input wire fh_frame_pkg::tx_req_t tx_req,
  input wire logic [7:0] tx_data,
  output logic tx_data_take,
  output logic tx_busy,
  output logic tx_bit,
  output logic tx_bit_strobe,
  output logic tx_done,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  output logic [2:0] rx_rate,
  output logic rx_in_frame,
  output logic [7:0] rx_data,
  output logic rx_data_valid,
  output logic rx_done,
  output fh_frame_pkg::rx_status_t rx_status,
  output logic [63:0] local_time
);
  import fh_frame_pkg::*;

  tx_state_t tx_state; // transmit phase
  tx_req_t tx_cfg_reg; // request latched at start
  logic [8:0] tx_div; // cycles left in current bit
  logic [6:0] tx_cnt; // bit index inside phase
  logic [11:0] tx_idx; // MAC byte index
  logic [7:0] tx_byte; // byte being serialised
  logic [63:0] tx_ts; // local time when the frame went on air
  logic tx_tick; // emit next bit
  logic tx_cur; // bit to emit on this tick
  logic tx_load; // take a new MAC byte on this tick
  logic [7:0] tx_next_byte; // byte after version/timestamp substitution
  logic [15:0] tx_hdr; // {signal, length} sent lsb first
  logic [11:0] tx_off; // byte offset into timestamp
  logic [15:0] tx_hec; // header check remainder
  logic [31:0] tx_fcs; // frame check remainder
  logic [8:0] tx_period; // cycles of the bit being emitted

  rx_state_t rx_state; // receive phase
  logic [15:0] rx_sr; // delimiter hunt / header field shifter
  logic [6:0] rx_cnt; // bit index inside phase
  logic [11:0] rx_len; // MAC bytes expected, trailing check excluded
  logic [11:0] rx_idx; // MAC byte index
  logic [7:0] rx_byte; // assembling byte, lsb first
  logic [31:0] rx_chk; // received check bits, msb first
  logic rx_ver_bad; // version field was nonzero
  logic rx_beacon; // frame control says beacon
  logic [63:0] rx_ts; // timestamp carried by a received beacon
  logic [63:0] rx_arrive; // local time at delimiter detect
  logic [15:0] rx_hec; // header check remainder
  logic [31:0] rx_fcs; // frame check remainder
  logic [15:0] rx_sr_in; // shifter with the new bit
  logic [7:0] rx_byte_in; // byte with the new bit
  logic [31:0] rx_chk_in; // check bits with the new bit
  logic rx_fix; // apply beacon correction this cycle
  logic [7:0] us_div; // microsecond divider
  logic us_tick; // one-cycle microsecond enable

  // transmit bit timing: preamble and header at base rate, payload at chosen rate
  assign tx_period = (tx_state == TX_DATA || tx_state == TX_FCS) ?
                     bit_cycles(tx_cfg_reg.rate) : 9'(BASE_BIT_CYCLES);
  assign tx_tick = (tx_state != TX_IDLE) && (tx_div == 9'h000);
  assign tx_busy = (tx_state != TX_IDLE);
  assign tx_hdr = {4'(tx_cfg_reg.rate), tx_cfg_reg.len + FCS_BYTES};
  assign tx_off = tx_idx - TS_FIRST_BYTE;

  // pick the bit for the current phase
  always_comb begin
    case (tx_state)
      TX_SYNC: tx_cur = tx_cnt[0]; // 0101...
      TX_SFD: tx_cur = SFD_PATTERN[4'hF - tx_cnt[3:0]];
      TX_HDR: tx_cur = (tx_cnt < HDR_FIELD_BITS) ? tx_hdr[tx_cnt[3:0]] :
                       ~tx_hec[4'hF - tx_cnt[3:0]];
      TX_DATA: tx_cur = tx_byte[tx_cnt[2:0]];
      TX_FCS: tx_cur = ~tx_fcs[5'h1F - tx_cnt[4:0]];
      default: tx_cur = 1'b0;
    endcase
  end

  // byte loads happen at the header-to-data edge and after each data byte but the last
  always_comb begin
    tx_load = 1'b0;
    if (tx_tick) begin
      if (tx_state == TX_HDR && tx_cnt == HDR_FIELD_BITS + HEC_BITS - 7'h01) begin
        tx_load = (tx_cfg_reg.len != 12'h000);
      end else if (tx_state == TX_DATA && tx_cnt[2:0] == 3'h7) begin
        tx_load = (tx_idx + 12'h001 != tx_cfg_reg.len);
      end
    end
  end
  assign tx_data_take = tx_load;

  // substitute the version bits and, for beacons, the on-air timestamp
  always_comb begin
    tx_next_byte = tx_data;
    if (tx_state == TX_HDR) begin
      tx_next_byte[1:0] = VERSION_ZERO;
    end else if (tx_cfg_reg.beacon && tx_idx + 12'h001 >= TS_FIRST_BYTE &&
                 tx_idx + 12'h001 < TS_FIRST_BYTE + TS_BYTES) begin
      // wrap the byte offset in three bits so stamp byte 0 never indexes past the word
      tx_next_byte = tx_ts[8 * 3'(tx_off + 12'h001) +: 8];
    end
  end

  // transmit sequencer: one step per bit tick
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_cfg_reg <= '0;
      tx_div <= 9'h000;
      tx_cnt <= 7'h00;
      tx_idx <= 12'h000;
      tx_byte <= 8'h00;
      tx_ts <= 64'h0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tx_state == TX_IDLE) begin
        if (tx_start) begin
          tx_state <= TX_SYNC;
          tx_cfg_reg <= tx_req;
          tx_cnt <= 7'h00;
          tx_div <= 9'h000;
          tx_ts <= local_time; // first sync bit leaves now
        end
      end else if (!tx_tick) begin
        tx_div <= tx_div - 9'h001;
      end else begin
        tx_div <= tx_period - 9'h001;
        tx_cnt <= tx_cnt + 7'h01;
        if (tx_load) begin
          tx_byte <= tx_next_byte;
        end
        case (tx_state)
          TX_SYNC: if (tx_cnt == SYNC_BITS - 7'h01) begin
            tx_state <= TX_SFD;
            tx_cnt <= 7'h00;
          end
          TX_SFD: if (tx_cnt == SFD_BITS - 7'h01) begin
            tx_state <= TX_HDR;
            tx_cnt <= 7'h00;
          end
          TX_HDR: if (tx_cnt == HDR_FIELD_BITS + HEC_BITS - 7'h01) begin
            // an empty body goes straight to the trailing check
            tx_state <= (tx_cfg_reg.len == 12'h000) ? TX_FCS : TX_DATA;
            tx_cnt <= 7'h00;
            tx_idx <= 12'h000;
          end
          TX_DATA: if (tx_cnt[2:0] == 3'h7) begin
            tx_cnt <= 7'h00;
            tx_idx <= tx_idx + 12'h001;
            if (!tx_load) begin
              tx_state <= TX_FCS;
            end
          end
          TX_FCS: if (tx_cnt == FCS_BITS - 7'h01) begin
            tx_state <= TX_IDLE;
            tx_done <= 1'b1;
          end
          default: tx_state <= TX_IDLE;
        endcase
      end
    end
  end

  // serial output register, one strobe per emitted bit
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_bit <= 1'b0;
      tx_bit_strobe <= 1'b0;
    end else begin
      tx_bit_strobe <= tx_tick;
      if (tx_tick) begin
        tx_bit <= tx_cur;
      end
    end
  end

  fh_crc_serial #(.W(16), .POLY(HEC_POLY)) u_tx_hec (
    .mclk(mclk), .rst(rst), .clear(tx_start && !tx_busy),
    .shift_en(tx_tick && tx_state == TX_HDR && tx_cnt < HDR_FIELD_BITS),
    .din(tx_cur), .crc(tx_hec)
  );
  fh_crc_serial #(.W(32), .POLY(FCS_POLY)) u_tx_fcs (
    .mclk(mclk), .rst(rst), .clear(tx_start && !tx_busy),
    .shift_en(tx_tick && tx_state == TX_DATA), .din(tx_cur), .crc(tx_fcs)
  );

  assign rx_sr_in = {rx_sr[14:0], rx_bit};
  assign rx_byte_in = {rx_bit, rx_byte[7:1]};
  assign rx_chk_in = {rx_chk[30:0], rx_bit};

  // receive parser: hunt, header, body, trailing check
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_state <= RX_HUNT;
      rx_sr <= 16'h0000;
      rx_cnt <= 7'h00;
      rx_len <= 12'h000;
      rx_idx <= 12'h000;
      rx_byte <= 8'h00;
      rx_chk <= 32'h0;
      rx_ver_bad <= 1'b0;
      rx_beacon <= 1'b0;
      rx_ts <= 64'h0;
      rx_arrive <= 64'h0;
      rx_rate <= 3'h0;
      rx_data <= 8'h00;
      rx_data_valid <= 1'b0;
      rx_done <= 1'b0;
      rx_status <= '0;
      rx_fix <= 1'b0;
    end else begin
      rx_data_valid <= 1'b0;
      rx_done <= 1'b0;
      rx_fix <= 1'b0;
      if (rx_bit_valid) begin
        rx_cnt <= rx_cnt + 7'h01;
        case (rx_state)
          RX_HUNT: begin
            rx_sr <= rx_sr_in;
            if (rx_sr_in == SFD_PATTERN) begin
              rx_state <= RX_HDR; // frame timing starts here
              rx_cnt <= 7'h00;
              rx_arrive <= local_time;
            end
          end
          RX_HDR: begin
            if (rx_cnt < HDR_FIELD_BITS) begin
              rx_sr <= {rx_bit, rx_sr[15:1]};
            end else begin
              rx_chk <= rx_chk_in;
            end
            if (rx_cnt == HDR_FIELD_BITS + HEC_BITS - 7'h01) begin
              rx_cnt <= 7'h00;
              rx_idx <= 12'h000;
              rx_ver_bad <= 1'b0;
              rx_beacon <= 1'b0;
              if (rx_chk_in[15:0] == ~rx_hec && rx_sr[15:12] <= MAX_RATE_CODE &&
                  rx_sr[11:0] >= FCS_BYTES) begin
                rx_rate <= rx_sr[14:12]; // payload rate
                rx_len <= rx_sr[11:0] - FCS_BYTES;
                rx_state <= (rx_sr[11:0] == FCS_BYTES) ? RX_FCS : RX_DATA;
              end else begin
                rx_state <= RX_HUNT;
                rx_sr <= 16'h0000;
                rx_done <= 1'b1;
                rx_status <= '{ok: 1'b0, hdr_err: 1'b1, fcs_err: 1'b0, ver_err: 1'b0};
              end
            end
          end
          RX_DATA: begin
            rx_byte <= rx_byte_in;
            if (rx_cnt[2:0] == 3'h7) begin
              rx_cnt <= 7'h00;
              rx_data <= rx_byte_in;
              rx_data_valid <= 1'b1;
              rx_idx <= rx_idx + 12'h001;
              if (rx_idx == 12'h000) begin
                rx_ver_bad <= (rx_byte_in[1:0] != VERSION_ZERO);
                rx_beacon <= (rx_byte_in == BEACON_FC);
              end
              if (rx_idx >= TS_FIRST_BYTE && rx_idx < TS_FIRST_BYTE + TS_BYTES) begin
                rx_ts <= {rx_byte_in, rx_ts[63:8]};
              end
              if (rx_idx + 12'h001 == rx_len) begin
                rx_state <= RX_FCS; // byte count reached
              end
            end
          end
          RX_FCS: begin
            rx_chk <= rx_chk_in;
            if (rx_cnt == FCS_BITS - 7'h01) begin
              rx_state <= RX_HUNT;
              rx_sr <= 16'h0000;
              rx_done <= 1'b1;
              rx_status.hdr_err <= 1'b0;
              rx_status.fcs_err <= (rx_chk_in != ~rx_fcs);
              rx_status.ver_err <= rx_ver_bad;
              rx_status.ok <= (rx_chk_in == ~rx_fcs) && !rx_ver_bad;
              rx_fix <= (rx_chk_in == ~rx_fcs) && !rx_ver_bad && rx_beacon &&
                        (rx_len >= TS_FIRST_BYTE + TS_BYTES);
            end
          end
          default: rx_state <= RX_HUNT;
        endcase
      end
    end
  end
  assign rx_in_frame = (rx_state != RX_HUNT);

  fh_crc_serial #(.W(16), .POLY(HEC_POLY)) u_rx_hec (
    .mclk(mclk), .rst(rst), .clear(rx_state == RX_HUNT),
    .shift_en(rx_bit_valid && rx_state == RX_HDR && rx_cnt < HDR_FIELD_BITS),
    .din(rx_bit), .crc(rx_hec)
  );
  fh_crc_serial #(.W(32), .POLY(FCS_POLY)) u_rx_fcs (
    .mclk(mclk), .rst(rst), .clear(rx_state == RX_HUNT),
    .shift_en(rx_bit_valid && rx_state == RX_DATA), .din(rx_bit), .crc(rx_fcs)
  );

  // microsecond enable for the local clock
  assign us_tick = (us_div == 8'(US_CYCLES - 1));
  always_ff @(posedge mclk) begin
    if (rst || us_tick) begin
      us_div <= 8'h00;
    end else begin
      us_div <= us_div + 8'h01;
    end
  end

  // local clock: counts microseconds, snapped to a good beacon's time;
  // the beacon time plus sync/delimiter airtime plus time since arrival
  always_ff @(posedge mclk) begin
    if (rst) begin
      local_time <= 64'h0;
    end else if (rx_fix) begin
      local_time <= rx_ts + PREAMBLE_US + (local_time - rx_arrive);
    end else if (us_tick) begin
      local_time <= local_time + 64'h1;
    end
  end
endmodule : fh_phy_frame_framer
`default_nettype wire

// [framer_assertions.sv]
// port checker for the frame builder/parser, attached by bind below
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module framer_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tx_start,
  input wire logic tx_data_take,
  input wire logic tx_busy,
  input wire logic tx_bit,
  input wire logic tx_bit_strobe,
  input wire logic tx_done,
  input wire logic rx_bit_valid,
  input wire logic rx_in_frame,
  input wire logic rx_data_valid,
  input wire logic rx_done,
  input wire fh_frame_pkg::rx_status_t rx_status
);
  import fh_frame_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // a start the transmitter accepts; busy is combinational so this is exact
  logic take;
  assign take = tx_start && !tx_busy;
  chk_busy_follows: assert property (take |=> tx_busy)
    else $error("busy missing after start");
  chk_first_bit: assert property (take |-> ##2 (tx_bit_strobe && !tx_bit))
    else $error("first sync bit wrong");
  chk_second_bit: assert property (take |-> ##252 (tx_bit_strobe && tx_bit))
    else $error("sync bit period or value wrong");
  chk_strobe_pulse: assert property (tx_bit_strobe |=> !tx_bit_strobe)
    else $error("bit strobe longer than one cycle");
  // strobe is registered, so the last check bit shows just after busy drops
  chk_strobe_busy: assert property (tx_bit_strobe |-> $past(tx_busy))
    else $error("bit strobe outside a frame");
  chk_done_tail: assert property (tx_done |-> !tx_busy && tx_bit_strobe)
    else $error("done not with last check bit");
  // take is combinational on the tick, the strobe follows one edge later
  chk_take_tick: assert property (tx_data_take |=> tx_bit_strobe)
    else $error("byte taken off a bit tick");
  chk_byte_strobe: assert property (
    rx_data_valid |-> $past(rx_bit_valid) && $past(rx_in_frame))
    else $error("byte not after a bit in frame");
  chk_done_strobe: assert property (rx_done |-> $past(rx_bit_valid))
    else $error("frame end not after a bit");
  // version and trailing check errors may come together; ok only when none is set
  chk_status_one: assert property (
    rx_done |-> (rx_status.ok == !(rx_status.hdr_err || rx_status.fcs_err || rx_status.ver_err)))
    else $error("ok flag disagrees with error flags");
  chk_status_hold: assert property (!rx_done |-> $stable(rx_status))
    else $error("status moved without frame end");
  chk_hdr_drop: assert property (rx_done && rx_status.hdr_err |=> !rx_in_frame)
    else $error("frame kept after header error");
  // main scenarios
  cover property (take);
  cover property (rx_done && rx_status.ok);
  cover property (rx_done && rx_status.hdr_err);
  cover property (rx_done && rx_status.ver_err);
endmodule : framer_assertions
bind fh_phy_frame_framer framer_assertions i_chk (.mclk(mclk), .rst(rst), .tx_start(tx_start),
  .tx_data_take(tx_data_take), .tx_busy(tx_busy), .tx_bit(tx_bit),
  .tx_bit_strobe(tx_bit_strobe), .tx_done(tx_done), .rx_bit_valid(rx_bit_valid),
  .rx_in_frame(rx_in_frame), .rx_data_valid(rx_data_valid), .rx_done(rx_done),
  .rx_status(rx_status));
`default_nettype wire

// [remote_station.sv]
// remote station model: hears transmitted bits and sends receive frames
// assumes the bench calls build then send; bits go out two clocks apart
`timescale 1ns/1ns
`default_nettype none
module remote_station (
  input wire logic mclk,
  input wire logic tx_bit,
  input wire logic tx_bit_strobe,
  output logic rx_bit,
  output logic rx_bit_valid
);
  import fh_frame_pkg::*;
  logic fr[$]; // frame bits in air order
  logic heard[$]; // bits heard from the transmitter
  initial begin
    rx_bit = 1'b0;
    rx_bit_valid = 1'b0;
  end
  // strobe and bit are registered together, so sample them one edge later
  always @(posedge mclk) begin
    if (tx_bit_strobe) heard.push_back(tx_bit);
  end
  // payload bytes; byte 0 is a data frame control byte, never a beacon
  function automatic logic [7:0] data_byte(input int k);
    data_byte = (k == 0) ? 8'h08 : 8'(8'h3B + 8'(k) * 8'h29);
  endfunction : data_byte
  // msb-first crc preset to ones over a stretch of the frame
  function automatic logic [31:0] crc(input int s, input int n, input int w);
    logic [31:0] c;
    logic fb;
    c = '1;
    for (int i = 0; i < n; i++) begin
      fb = c[w-1] ^ fr[s+i];
      c = c << 1;
      if (fb) c = c ^ ((w == 16) ? {16'h0000, HEC_POLY} : FCS_POLY);
    end
    crc = c;
  endfunction : crc
  task automatic put_bits(input logic [31:0] v, input int n, input logic lsb);
    for (int i = 0; i < n; i++) fr.push_back(lsb ? v[i] : v[n-1-i]);
  endtask : put_bits
  // payload byte k as it goes on air; a beacon carries its type byte and stamp
  function automatic logic [7:0] air_byte(input int k, input logic bcn,
                                           input logic [63:0] ts);
    if (bcn && k == 0) air_byte = BEACON_FC;
    else if (bcn && k >= int'(TS_FIRST_BYTE) && k < int'(TS_FIRST_BYTE + TS_BYTES))
      air_byte = ts[8 * (k - int'(TS_FIRST_BYTE)) +: 8];
    else air_byte = data_byte(k);
  endfunction : air_byte
  // bad[0] spoils the header check, bad[1] the trailing check
  task automatic build(input logic [11:0] len, input logic [2:0] rate,
                       input logic [1:0] ver, input logic [1:0] bad,
                       input logic bcn, input logic [63:0] ts);
    logic [31:0] c;
    fr.delete();
    for (int i = 0; i < 80; i++) fr.push_back(i[0]);
    put_bits({16'h0000, SFD_PATTERN}, 16, 1'b0);
    put_bits({20'h00000, len + FCS_BYTES}, 12, 1'b1);
    put_bits({29'h0, rate}, 4, 1'b1);
    c = ~crc(96, 16, 16);
    put_bits(c ^ {31'h0, bad[0]}, 16, 1'b0);
    for (int k = 0; k < int'(len); k++) begin
      put_bits({24'h0, air_byte(k, bcn, ts) | {6'h00, ver}}, 8, 1'b1);
    end
    c = ~crc(128, 8 * int'(len), 32);
    put_bits(c ^ {31'h0, bad[1]}, 32, 1'b0);
  endtask : build
  task automatic send();
    foreach (fr[i]) begin
      @(negedge mclk);
      rx_bit = fr[i];
      rx_bit_valid = 1'b1;
      @(negedge mclk);
      rx_bit_valid = 1'b0;
      rx_bit = ~fr[i]; // released line shows the inverse, not a held value
    end
  endtask : send
endmodule : remote_station
`default_nettype wire

// [testbench.sv]
// self-checking bench: frame builder/parser against the remote station model
// assumes the package, the framer and the station model are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import fh_frame_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic tx_start = 1'b0;
  tx_req_t tx_req = '0;
  logic [7:0] tx_data = 8'h00;
  logic tx_data_take, tx_busy, tx_bit, tx_bit_strobe, tx_done, rx_bit, rx_bit_valid;
  logic [2:0] rx_rate;
  logic rx_in_frame, rx_data_valid, rx_done;
  logic [7:0] rx_data;
  rx_status_t rx_status;
  logic [63:0] local_time;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0; // cycle count for the hang limit
  int k = 0; // index of the byte offered to the transmitter
  logic dn = 1'b0; // frame end seen
  logic took = 1'b0; // a byte was taken at the last rising edge
  rx_status_t st; // status captured at frame end
  logic [7:0] rxq[$]; // bytes handed up by the receiver
  always #2 mclk = ~mclk;
  fh_phy_frame_framer i_dut (.mclk(mclk), .rst(rst), .tx_start(tx_start), .tx_req(tx_req),
    .tx_data(tx_data), .tx_data_take(tx_data_take), .tx_busy(tx_busy), .tx_bit(tx_bit),
    .tx_bit_strobe(tx_bit_strobe), .tx_done(tx_done), .rx_bit(rx_bit),
    .rx_bit_valid(rx_bit_valid), .rx_rate(rx_rate), .rx_in_frame(rx_in_frame),
    .rx_data(rx_data), .rx_data_valid(rx_data_valid), .rx_done(rx_done),
    .rx_status(rx_status), .local_time(local_time));
  remote_station i_peer (.mclk(mclk), .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
    .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));
  // receiver capture
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    took <= tx_data_take;
    if (rx_data_valid) rxq.push_back(rx_data);
    if (rx_done) begin
      dn <= 1'b1;
      st <= rx_status;
    end
  end
  // a hang counts as a mismatch
  always @(posedge mclk) begin
    if (cyc == 95000) begin
      fail_count++;
      close_out();
    end
  end
  // next byte goes up only after the edge that took the previous one
  always @(negedge mclk) begin
    if (took) begin
      k = k + 1;
      tx_data = i_peer.data_byte(k);
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // one frame out at the top rate, with a second start while busy;
  // a beacon must carry the clock value of its start edge
  task automatic t_tx(input logic bcn, input logic [11:0] len);
    int diff;
    int n;
    i_peer.heard.delete();
    k = 0;
    @(negedge mclk);
    tx_data = (bcn ? BEACON_FC : i_peer.data_byte(0)) | 8'h03; // version bits set on purpose
    tx_req = '{beacon: bcn, rate: 3'h7, len: len};
    tx_start = 1'b1;
    i_peer.build(len, 3'h7, 2'h0, 2'h0, bcn, local_time);
    @(negedge mclk);
    tx_start = 1'b0;
    repeat (1000) @(negedge mclk);
    tx_start = 1'b1; // must be ignored
    @(negedge mclk);
    tx_start = 1'b0;
    n = 0;
    while (!tx_done && n < 50000) begin
      @(negedge mclk);
      n++;
    end
    repeat (20) @(negedge mclk);
    check(32'(tx_busy), 32'h0);
    check(32'(i_peer.heard.size()), 32'(i_peer.fr.size()));
    diff = 0;
    foreach (i_peer.fr[i]) if (i_peer.heard[i] !== i_peer.fr[i]) diff++;
    check(32'(diff), 32'h0);
  endtask : t_tx
  // one received frame; n < 0 leaves the byte count unjudged
  task automatic t_rx(input logic [2:0] rate, input logic [1:0] ver, input logic [1:0] bad,
                      input logic [3:0] exp_st, input int n);
    rxq.delete();
    dn = 1'b0;
    i_peer.build(12'h003, rate, ver, bad, 1'b0, 64'h0);
    i_peer.send();
    repeat (20) @(negedge mclk);
    check(32'(dn), 32'h1);
    check(32'(st), 32'(exp_st));
    if (n >= 0) check(32'(rxq.size()), 32'(n));
    if (n > 0) foreach (rxq[i]) check(32'(rxq[i]), 32'(i_peer.data_byte(i)));
    if (exp_st == 4'h8) check(32'(rx_rate), 32'(rate));
  endtask : t_rx
  task automatic t_rx_rates();
    for (int r = 0; r < 8; r++) t_rx(3'(r), 2'h0, 2'h0, 4'h8, 3);
  endtask : t_rx_rates
  task automatic t_rx_hdr_err();
    t_rx(3'h2, 2'h0, 2'h1, 4'h4, 0);
    t_rx(3'h2, 2'h0, 2'h0, 4'h8, 3);
  endtask : t_rx_hdr_err
  task automatic t_rx_version();
    for (int v = 1; v < 4; v++) t_rx(3'h1, 2'(v), 2'h0, 4'h1, -1);
  endtask : t_rx_version
  task automatic t_rx_fcs();
    t_rx(3'h5, 2'h0, 2'h2, 4'h2, -1);
  endtask : t_rx_fcs
  // a good beacon pulls the local clock to its stamp plus the preamble airtime
  task automatic t_rx_beacon();
    logic [63:0] ts;
    logic [63:0] d;
    ts = 64'h0123_4567_0000_0000;
    dn = 1'b0;
    i_peer.build(12'h020, 3'h3, 2'h0, 2'h0, 1'b1, ts);
    i_peer.send();
    repeat (20) @(negedge mclk);
    check(32'(dn), 32'h1);
    check(32'(st), 32'h8);
    d = local_time - ts - PREAMBLE_US;
    check(32'(d < 64'h8), 32'h1);
  endtask : t_rx_beacon
  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    t_tx(1'b0, 12'h003);
    t_tx(1'b1, 12'h020);
    t_rx_rates();
    t_rx_hdr_err();
    t_rx_version();
    t_rx_fcs();
    t_rx_beacon();
    close_out();
  end
endmodule : testbench
`default_nettype wire
